// File: hdl/ssc_standby_ctrl.sv
`timescale 1ns/1ps
`include "ssc_cfg.svh"
module ssc_standby_ctrl #(
    parameter int unsigned SUB_DIV = `SSC_SUB_DIV,
    parameter int RAM_AW = 8,
    parameter int RAM_DW = 32
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [`SSC_AW-1:0] reg_addr,
    input wire logic [`SSC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`SSC_DW-1:0] reg_rdata,
    input wire logic nmi_pin,
    input wire logic watchdog2_nonmaskable_irq,
    input wire logic watchdog2_reset,
    input wire logic [`SSC_EXT_IRQ_N-1:0] external_irq_pins,
    input wire ssc_pkg::ssc_periph_en_t periph_irq,
    input wire logic cpu_ram_we,
    input wire logic [RAM_AW-1:0] cpu_ram_addr,
    input wire logic [RAM_DW-1:0] cpu_ram_wdata,
    output logic [RAM_DW-1:0] cpu_ram_rdata,
    output logic cpu_clk_en,
    output logic sub_osc_en,
    output logic main_osc_en,
    output logic sub_tick,
    output ssc_pkg::ssc_periph_en_t periph_en,
    output ssc_pkg::ssc_state_t op_mode
);
    import ssc_pkg::*;

    localparam int DIV_W = $clog2(SUB_DIV);

    ssc_state_t state_reg;
    ssc_state_t state_next;
    logic power_save_mode_reg_reg;
    logic nmi_pin_dis_reg;
    logic nmi_wdt_dis_reg;
    logic maskable_dis_reg;
    logic subsel_reg;
    logic mstop_reg;
    ssc_clk_src_t src_reg;
    logic [`SSC_EXT_IRQ_N-1:0] ext_mask_reg;
    logic [`SSC_NPERIPH-1:0] per_mask_reg;
    logic wake_nmi_reg;
    logic wake_ext_reg;
    logic wake_per_reg;
    logic wake_rst_reg;
    logic [DIV_W-1:0] div_reg;
    logic sub_tick_reg;
    logic [`SSC_DW-1:0] rdata_reg;

    logic wr_psc;
    logic wr_clk;
    logic trig_wr;
    logic in_sub;
    logic main_stopped;
    logic wdt_rst_hit;
    logic nmi_wake;
    logic ext_wake;
    logic per_wake;
    logic any_wake;

    // Run enables for every unit from mode, main clock state and count clock choices
    function automatic ssc_periph_en_t calc_periph_en(
        input ssc_state_t st,
        input logic stopped,
        input ssc_clk_src_t src
    );
        ssc_periph_en_t en;
        logic idle;
        logic restricted;
        en = '1;
        idle = (st == ssc_sub_idle);
        restricted = idle || stopped;
        if (st != ssc_normal) begin
            en.first_watchdog = 1'b0;
        end
        if (restricted) begin
            en.irq_controller = !idle;
            en.key_irq = 1'b1;
            en.timer_p_unit = 1'b0;
            en.sixteen_bit_timer = src.sixteen_src_watch_timer_irq && (!stopped || src.wt_src_sub);
            en.eight_bit_timer = src.eight_src_eight_bit_timer_ext_input
                | (src.eight_src_sixteen_bit_compare_irq & {2{en.sixteen_bit_timer}});
            en.first_h_timer = 1'b0;
            en.second_h_timer = src.second_h_src_sub;
            en.watch_timer = stopped ? src.wt_src_sub : 1'b1;
            en.second_watchdog = src.wdt2_src_sub;
            en.clocked_serial_channel_a = src.serial_clock_ext_input[0];
            en.clocked_serial_channel_b = src.serial_clock_ext_input[1];
            en.i2c_unit = 1'b0;
            en.first_async_serial = src.uart_ext_baud_clock;
            en.second_async_serial = 1'b0;
            en.adc_unit = 1'b0;
            en.realtime_output = src.rto_trig_eight_bit_timer_irq
                && src.eight_src_eight_bit_timer_ext_input[src.rto_timer_sel];
        end
        return en;
    endfunction : calc_periph_en

    assign wr_psc = reg_wr && (reg_addr == `SSC_OFF_PSC);
    assign wr_clk = reg_wr && (reg_addr == `SSC_OFF_CLK);
    assign trig_wr = wr_psc && reg_wdata[`SSC_PSC_TRIG_BIT];
    assign in_sub = (state_reg != ssc_normal);
    assign main_stopped = mstop_reg && in_sub;
    assign wdt_rst_hit = watchdog2_reset && in_sub;

    // Release sources, only looked at while idling
    assign nmi_wake = (nmi_pin && !nmi_pin_dis_reg)
        || (watchdog2_nonmaskable_irq && !nmi_wdt_dis_reg);
    assign ext_wake = !maskable_dis_reg && |(external_irq_pins & ~ext_mask_reg);
    assign per_wake = !maskable_dis_reg
        && |(periph_irq & ~per_mask_reg & periph_en);
    assign any_wake = nmi_wake || ext_wake || per_wake;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ssc_normal: begin
                if (wr_clk && reg_wdata[`SSC_CLK_SUBSEL_BIT]) begin
                    state_next = ssc_subclk;
                end
            end
            ssc_subclk: begin
                if (wr_clk && !reg_wdata[`SSC_CLK_SUBSEL_BIT]) begin
                    state_next = ssc_normal;
                end else if (trig_wr && !power_save_mode_reg_reg) begin
                    state_next = ssc_sub_idle;
                end
            end
            ssc_sub_idle: begin
                if (any_wake) begin
                    state_next = ssc_subclk;
                end
            end
            default: begin
                state_next = ssc_normal;
            end
        endcase
        if (wdt_rst_hit) begin
            state_next = ssc_normal;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ssc_normal;
        end else begin
            state_reg <= state_next;
        end
    end

    // Control registers; a second watchdog reset in subclock or sub-IDLE mode behaves like a full reset, in normal mode it is ignored
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            power_save_mode_reg_reg <= `SSC_POWER_SAVE_MODE_REG_RST;
            nmi_pin_dis_reg <= 1'b0;
            nmi_wdt_dis_reg <= 1'b0;
            maskable_dis_reg <= 1'b0;
            subsel_reg <= 1'b0;
            mstop_reg <= 1'b0;
            src_reg <= `SSC_SRC_RST;
            ext_mask_reg <= `SSC_EXTMASK_RST;
            per_mask_reg <= `SSC_PERMASK_RST;
        end else if (wdt_rst_hit) begin
            power_save_mode_reg_reg <= `SSC_POWER_SAVE_MODE_REG_RST;
            nmi_pin_dis_reg <= 1'b0;
            nmi_wdt_dis_reg <= 1'b0;
            maskable_dis_reg <= 1'b0;
            subsel_reg <= 1'b0;
            mstop_reg <= 1'b0;
            src_reg <= `SSC_SRC_RST;
            ext_mask_reg <= `SSC_EXTMASK_RST;
            per_mask_reg <= `SSC_PERMASK_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `SSC_OFF_PSC: begin
                    nmi_pin_dis_reg <= reg_wdata[`SSC_PSC_NMIPIN_DIS_BIT];
                    nmi_wdt_dis_reg <= reg_wdata[`SSC_PSC_NMIWDT_DIS_BIT];
                    maskable_dis_reg <= reg_wdata[`SSC_PSC_MASKABLE_DIS_BIT];
                end
                `SSC_OFF_POWER_SAVE_MODE_REG: begin
                    power_save_mode_reg_reg <= reg_wdata[`SSC_POWER_SAVE_MODE_REG_SEL_BIT];
                end
                `SSC_OFF_CLK: begin
                    subsel_reg <= reg_wdata[`SSC_CLK_SUBSEL_BIT];
                    mstop_reg <= reg_wdata[`SSC_CLK_MSTOP_BIT];
                end
                `SSC_OFF_SRC: begin
                    src_reg <= reg_wdata[`SSC_SRC_W-1:0];
                end
                `SSC_OFF_EXTMASK: begin
                    ext_mask_reg <= reg_wdata[`SSC_EXT_IRQ_N-1:0];
                end
                `SSC_OFF_PERMASK: begin
                    per_mask_reg <= reg_wdata[`SSC_NPERIPH-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Sticky wake cause flags, write one to clear, a new event wins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wake_nmi_reg <= 1'b0;
            wake_ext_reg <= 1'b0;
            wake_per_reg <= 1'b0;
            wake_rst_reg <= 1'b0;
        end else begin
            if (state_reg == ssc_sub_idle && !wdt_rst_hit && nmi_wake) begin
                wake_nmi_reg <= 1'b1;
            end else if (reg_wr && reg_addr == `SSC_OFF_STAT && reg_wdata[`SSC_STAT_WNMI_BIT]) begin
                wake_nmi_reg <= 1'b0;
            end
            if (state_reg == ssc_sub_idle && !wdt_rst_hit && ext_wake) begin
                wake_ext_reg <= 1'b1;
            end else if (reg_wr && reg_addr == `SSC_OFF_STAT && reg_wdata[`SSC_STAT_WEXT_BIT]) begin
                wake_ext_reg <= 1'b0;
            end
            if (state_reg == ssc_sub_idle && !wdt_rst_hit && per_wake) begin
                wake_per_reg <= 1'b1;
            end else if (reg_wr && reg_addr == `SSC_OFF_STAT && reg_wdata[`SSC_STAT_WPER_BIT]) begin
                wake_per_reg <= 1'b0;
            end
            if (wdt_rst_hit) begin
                wake_rst_reg <= 1'b1;
            end else if (reg_wr && reg_addr == `SSC_OFF_STAT && reg_wdata[`SSC_STAT_WRST_BIT]) begin
                wake_rst_reg <= 1'b0;
            end
        end
    end

    // Subclock rate enable, free running in every mode
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= '0;
            sub_tick_reg <= 1'b0;
        end else if (div_reg == DIV_W'(SUB_DIV - 1)) begin
            div_reg <= '0;
            sub_tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 1'b1;
            sub_tick_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            rdata_reg <= '0;
            unique case (reg_addr)
                `SSC_OFF_PSC: begin
                    rdata_reg[`SSC_PSC_NMIPIN_DIS_BIT] <= nmi_pin_dis_reg;
                    rdata_reg[`SSC_PSC_NMIWDT_DIS_BIT] <= nmi_wdt_dis_reg;
                    rdata_reg[`SSC_PSC_MASKABLE_DIS_BIT] <= maskable_dis_reg;
                end
                `SSC_OFF_POWER_SAVE_MODE_REG: begin
                    rdata_reg[`SSC_POWER_SAVE_MODE_REG_SEL_BIT] <= power_save_mode_reg_reg;
                end
                `SSC_OFF_CLK: begin
                    rdata_reg[`SSC_CLK_SUBSEL_BIT] <= subsel_reg;
                    rdata_reg[`SSC_CLK_MSTOP_BIT] <= mstop_reg;
                end
                `SSC_OFF_SRC: begin
                    rdata_reg[`SSC_SRC_W-1:0] <= src_reg;
                end
                `SSC_OFF_EXTMASK: begin
                    rdata_reg[`SSC_EXT_IRQ_N-1:0] <= ext_mask_reg;
                end
                `SSC_OFF_PERMASK: begin
                    rdata_reg[`SSC_NPERIPH-1:0] <= per_mask_reg;
                end
                `SSC_OFF_STAT: begin
                    rdata_reg[`SSC_STAT_STATE_LSB +: 2] <= state_reg;
                    rdata_reg[`SSC_STAT_WNMI_BIT] <= wake_nmi_reg;
                    rdata_reg[`SSC_STAT_WEXT_BIT] <= wake_ext_reg;
                    rdata_reg[`SSC_STAT_WPER_BIT] <= wake_per_reg;
                    rdata_reg[`SSC_STAT_WRST_BIT] <= wake_rst_reg;
                end
                default: begin
                end
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    // RAM sees no clock while idling, so its contents and read data hold
    ssc_retention_ram #(
        .AW(RAM_AW),
        .DW(RAM_DW)
    ) u_ram (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(cpu_clk_en),
        .we(cpu_ram_we),
        .addr(cpu_ram_addr),
        .wdata(cpu_ram_wdata),
        .rdata(cpu_ram_rdata)
    );

    assign cpu_clk_en = (state_reg != ssc_sub_idle);
    assign sub_osc_en = 1'b1;
    assign main_osc_en = !main_stopped;
    assign sub_tick = sub_tick_reg;
    assign periph_en = calc_periph_en(state_reg, main_stopped, src_reg);
    assign op_mode = state_reg;
    assign reg_rdata = rdata_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_idle_req;
        state_reg == ssc_subclk && trig_wr && !power_save_mode_reg_reg && !watchdog2_reset;
    endsequence

    sequence s_idle_wake_nmi;
        state_reg == ssc_sub_idle && nmi_wake && !watchdog2_reset;
    endsequence

    chk_idle_entry: assert property (s_idle_req |=> state_reg == ssc_sub_idle && !cpu_clk_en)
        else $error("sub-IDLE not entered after trigger");

    chk_cpu_gated: assert property (state_reg == ssc_sub_idle |-> !cpu_clk_en && sub_osc_en)
        else $error("CPU clock not gated in sub-IDLE");

    chk_ram_hold: assert property ((state_reg == ssc_sub_idle)[*2] |-> $stable(cpu_ram_rdata))
        else $error("RAM read data moved in sub-IDLE");

    chk_tick_period: assert property (sub_tick |-> div_reg == '0 ##1 !sub_tick)
        else $error("subclock tick malformed");

    chk_nmi_release: assert property (s_idle_wake_nmi |=> state_reg == ssc_subclk && wake_nmi_reg)
        else $error("NMI did not release sub-IDLE");

    chk_ext_release: assert property (state_reg == ssc_sub_idle && !maskable_dis_reg && !watchdog2_reset
        && |(external_irq_pins & ~ext_mask_reg) |=> state_reg == ssc_subclk && wake_ext_reg)
        else $error("external irq did not release sub-IDLE");

    chk_per_release: assert property (state_reg == ssc_sub_idle && per_wake && !watchdog2_reset
        |=> state_reg == ssc_subclk ##0 cpu_clk_en)
        else $error("peripheral irq did not release sub-IDLE");

    chk_masked_stay: assert property (state_reg == ssc_sub_idle && !any_wake && !watchdog2_reset
        |=> state_reg == ssc_sub_idle)
        else $error("sub-IDLE left without a source");

    chk_wdt_reset: assert property (in_sub && watchdog2_reset
        |=> state_reg == ssc_normal && !subsel_reg && main_osc_en)
        else $error("watchdog reset did not restore normal mode");

    chk_sub_exit: assert property (state_reg == ssc_subclk && wr_clk && !reg_wdata[`SSC_CLK_SUBSEL_BIT]
        && !watchdog2_reset |=> state_reg == ssc_normal && periph_en.first_watchdog)
        else $error("subclock mode not left on select clear");

    chk_timer16_gate: assert property (main_stopped && state_reg == ssc_subclk |-> periph_en.sixteen_bit_timer
        == (src_reg.sixteen_src_watch_timer_irq && src_reg.wt_src_sub))
        else $error("16-bit timer enable wrong with main clock stopped");

    chk_halted_units: assert property (main_stopped |-> !(periph_en.timer_p_unit || periph_en.first_h_timer
        || periph_en.i2c_unit || periph_en.second_async_serial || periph_en.adc_unit))
        else $error("unit running with main clock stopped");

    chk_sub_cpu_up: assert property (state_reg == ssc_subclk |-> cpu_clk_en && periph_en.irq_controller
        && periph_en.key_irq && !periph_en.first_watchdog)
        else $error("core units stopped in subclock mode");
endmodule : ssc_standby_ctrl

// File: common/ssc_cfg.svh
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

`define SSC_DW 32
`define SSC_AW 4
`define SSC_EXT_IRQ_N 8
`define SSC_SRC_W 13
`define SSC_NPERIPH 18

`define SSC_OFF_PSC 4'h0
`define SSC_OFF_POWER_SAVE_MODE_REG 4'h1
`define SSC_OFF_CLK 4'h2
`define SSC_OFF_SRC 4'h3
`define SSC_OFF_EXTMASK 4'h4
`define SSC_OFF_PERMASK 4'h5
`define SSC_OFF_STAT 4'h6

`define SSC_PSC_TRIG_BIT 0
`define SSC_PSC_NMIPIN_DIS_BIT 1
`define SSC_PSC_NMIWDT_DIS_BIT 2
`define SSC_PSC_MASKABLE_DIS_BIT 3
`define SSC_POWER_SAVE_MODE_REG_SEL_BIT 0
`define SSC_CLK_SUBSEL_BIT 0
`define SSC_CLK_MSTOP_BIT 1
`define SSC_STAT_STATE_LSB 0
`define SSC_STAT_WNMI_BIT 4
`define SSC_STAT_WEXT_BIT 5
`define SSC_STAT_WPER_BIT 6
`define SSC_STAT_WRST_BIT 7

`define SSC_POWER_SAVE_MODE_REG_RST 1'h0
`define SSC_EXTMASK_RST 8'hff
`define SSC_PERMASK_RST 18'h3_ffff
`define SSC_SRC_RST 13'h0000

`define SSC_CLK_HZ 250000000
`define SSC_SUBCLK_HZ 32768
`define SSC_SUB_DIV (`SSC_CLK_HZ / `SSC_SUBCLK_HZ)

`endif

// File: common/ssc_pkg.sv
package ssc_pkg;

    typedef enum logic [1:0] {
        ssc_normal = 2'b00,
        ssc_subclk = 2'b01,
        ssc_sub_idle = 2'b10
    } ssc_state_t;

    // One bit per peripheral unit, used for run enables and for irq lines
    typedef struct packed {
        logic irq_controller;
        logic key_irq;
        logic timer_p_unit;
        logic sixteen_bit_timer;
        logic [1:0] eight_bit_timer;
        logic first_h_timer;
        logic second_h_timer;
        logic watch_timer;
        logic first_watchdog;
        logic second_watchdog;
        logic clocked_serial_channel_a;
        logic clocked_serial_channel_b;
        logic i2c_unit;
        logic first_async_serial;
        logic second_async_serial;
        logic adc_unit;
        logic realtime_output;
    } ssc_periph_en_t;

    // Count clock source choices, bit 12 down to bit 0
    typedef struct packed {
        logic wdt2_src_sub;
        logic second_h_src_sub;
        logic uart_ext_baud_clock;
        logic [1:0] serial_clock_ext_input;
        logic rto_timer_sel;
        logic rto_trig_eight_bit_timer_irq;
        logic [1:0] eight_src_sixteen_bit_compare_irq;
        logic [1:0] eight_src_eight_bit_timer_ext_input;
        logic wt_src_sub;
        logic sixteen_src_watch_timer_irq;
    } ssc_clk_src_t;

endpackage : ssc_pkg

// File: hdl/ssc_retention_ram.sv
`timescale 1ns/1ps
module ssc_retention_ram #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    // Gated clock equivalent: nothing moves while clk_en is low
    always_ff @(posedge clk_sys) begin
        if (clk_en && we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (clk_en) begin
            rdata <= mem[addr];
        end
    end
endmodule : ssc_retention_ram

// File: testbench/tb_subclock_standby_control.sv
`timescale 1ns/1ps
`include "ssc_cfg.svh"
module tb_subclock_standby_control;
    import ssc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic nmi_pin = 1'b0;
    logic wdt_nmi = 1'b0;
    logic wdt_rst = 1'b0;
    logic [7:0] ext_pins = 8'h00;
    ssc_periph_en_t periph_irq = '0;
    logic ram_we = 1'b0;
    logic [7:0] ram_addr = 8'h00;
    logic [31:0] ram_wdata = 32'h0000_0000;
    logic [31:0] ram_rdata;
    logic cpu_clk_en, sub_osc_en, main_osc_en, sub_tick;
    ssc_periph_en_t periph_en;
    ssc_state_t op_mode;
    logic [31:0] seed = 32'h0000_e869;
    logic [31:0] ram_d;
    logic [12:0] src;
    logic [31:0] tick_seen = 32'h0000_0000;
    int miscompares = 0;
    int check_count = 0;

    always #2 clk_sys = ~clk_sys;

    ssc_standby_ctrl #(.SUB_DIV(8)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_pin(nmi_pin),
        .watchdog2_nonmaskable_irq(wdt_nmi), .watchdog2_reset(wdt_rst), .external_irq_pins(ext_pins),
        .periph_irq(periph_irq), .cpu_ram_we(ram_we), .cpu_ram_addr(ram_addr), .cpu_ram_wdata(ram_wdata),
        .cpu_ram_rdata(ram_rdata), .cpu_clk_en(cpu_clk_en), .sub_osc_en(sub_osc_en),
        .main_osc_en(main_osc_en), .sub_tick(sub_tick), .periph_en(periph_en), .op_mode(op_mode));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Run enables with main clock stopped: wdt2, second H, uart, csi b, csi a, rto, sixteen, eight[1:0]
    function automatic logic [8:0] exp_run(input logic [12:0] s);
        logic sixteen;
        logic [1:0] eight;
        sixteen = s[0] & s[1];
        eight = s[3:2] | (s[5:4] & {2{sixteen}});
        return {s[12], s[11], s[10], s[9], s[8], s[6] & s[2 + s[7]], sixteen, eight};
    endfunction : exp_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask : rd_chk

    task automatic enter_idle();
        wr(4'h2, 32'h0000_0001);
        wr(4'h0, 32'h0000_0001);
        check(op_mode, ssc_sub_idle);
        check({sub_osc_en, cpu_clk_en}, 2'b10);
        // Software's no-op run after the request: bus stays quiet
        repeat (5) @(posedge clk_sys);
    endtask : enter_idle

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    initial begin
        #40000;
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        check({op_mode, cpu_clk_en, main_osc_en}, 4'b0011);
        rd_chk(4'h1, 32'h0000_0000);
        rd_chk(4'h4, 32'h0000_00ff);
        rd_chk(4'h5, 32'h0003_ffff);
        rd_chk(4'hf, 32'h0000_0000);
        for (int i = 0; i < 32; i++) begin
            @(posedge clk_sys);
            #1;
            tick_seen = tick_seen + sub_tick;
        end
        check(tick_seen, 32'h0000_0004);
        $display("test reset done");
        // Trigger refused in normal mode and with mode select 1
        wr(4'h0, 32'h0000_0001);
        check(op_mode, ssc_normal);
        wr(4'h2, 32'h0000_0001);
        wr(4'h1, 32'h0000_0001);
        wr(4'h0, 32'h0000_0001);
        check(op_mode, ssc_subclk);
        wr(4'h1, 32'h0000_0000);
        ram_d = xs();
        @(posedge clk_sys);
        ram_we <= 1'b1;
        ram_addr <= 8'(xs());
        ram_wdata <= ram_d;
        @(posedge clk_sys);
        ram_we <= 1'b0;
        enter_idle();
        @(posedge clk_sys);
        ram_we <= 1'b1;
        ram_wdata <= ~ram_d;
        @(posedge clk_sys);
        ram_we <= 1'b0;
        nmi_pin <= 1'b1;
        @(posedge clk_sys);
        nmi_pin <= 1'b0;
        #1;
        check({op_mode, cpu_clk_en}, 3'b011);
        rd_chk(4'h6, 32'h0000_0011);
        @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        check(ram_rdata, ram_d);
        wr(4'h6, 32'h0000_00f0);
        $display("test nmi release done");
        wr(4'h4, 32'h0000_00fe);
        enter_idle();
        @(posedge clk_sys);
        ext_pins <= 8'h80;
        repeat (3) @(posedge clk_sys);
        #1;
        check(op_mode, ssc_sub_idle);
        @(posedge clk_sys);
        ext_pins <= 8'h81;
        @(posedge clk_sys);
        ext_pins <= 8'h00;
        #1;
        check(op_mode, ssc_subclk);
        rd_chk(4'h6, 32'h0000_0021);
        wr(4'h6, 32'h0000_00f0);
        $display("test external release done");
        wr(4'h5, 32'h0003_7dff);
        enter_idle();
        check({periph_en.watch_timer, periph_en.irq_controller}, 2'b10);
        @(posedge clk_sys);
        periph_irq <= 18'h0_8000;
        repeat (3) @(posedge clk_sys);
        #1;
        check(op_mode, ssc_sub_idle);
        @(posedge clk_sys);
        periph_irq <= 18'h0_8200;
        @(posedge clk_sys);
        periph_irq <= 18'h0_0000;
        #1;
        check(op_mode, ssc_subclk);
        rd_chk(4'h6, 32'h0000_0041);
        wr(4'h6, 32'h0000_00f0);
        $display("test peripheral release done");
        wr(4'h2, 32'h0000_0003);
        check(main_osc_en, 1'b0);
        check({periph_en.timer_p_unit, periph_en.first_h_timer, periph_en.i2c_unit, periph_en.second_async_serial,
            periph_en.adc_unit, periph_en.first_watchdog, periph_en.irq_controller, periph_en.key_irq},
            8'h03);
        for (int i = 0; i < 12; i++) begin
            src = (i == 0) ? 13'h0003 : 13'(xs());
            wr(4'h3, {19'h0, src});
            check({periph_en.second_watchdog, periph_en.second_h_timer, periph_en.first_async_serial,
                periph_en.clocked_serial_channel_b, periph_en.clocked_serial_channel_a, periph_en.realtime_output,
                periph_en.sixteen_bit_timer, periph_en.eight_bit_timer},
                exp_run(src));
        end
        $display("test availability done");
        enter_idle();
        @(posedge clk_sys);
        wdt_rst <= 1'b1;
        @(posedge clk_sys);
        wdt_rst <= 1'b0;
        #1;
        check({op_mode, cpu_clk_en}, 3'b001);
        rd_chk(4'h6, 32'h0000_0080);
        rd_chk(4'h4, 32'h0000_00ff);
        wr(4'h6, 32'h0000_00f0);
        // Enter with the NMI pin disabled: only the watchdog NMI may release
        wr(4'h2, 32'h0000_0001);
        wr(4'h0, 32'h0000_0003);
        @(posedge clk_sys);
        nmi_pin <= 1'b1;
        @(posedge clk_sys);
        nmi_pin <= 1'b0;
        #1;
        check(op_mode, ssc_sub_idle);
        @(posedge clk_sys);
        wdt_nmi <= 1'b1;
        @(posedge clk_sys);
        wdt_nmi <= 1'b0;
        #1;
        check(op_mode, ssc_subclk);
        wr(4'h2, 32'h0000_0000);
        check(op_mode, ssc_normal);
        enter_idle();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        check({op_mode, cpu_clk_en}, 3'b001);
        rd_chk(4'h2, 32'h0000_0000);
        $display("test reset release done");
        end_sim();
    end
endmodule : tb_subclock_standby_control
